// ===== bgd_defines.svh
// Purpose: Named constants for the background debug link and its two ends
// Assumes: Included by the package and by both end modules
// Notes:   Counts are in debug clock ticks except BGD_ALT_LAST, BGD_BUS_LAST, BGD_SLOW_DIV and BGD_HOST_LOW, in clk_sys cycles
`ifndef BGD_DEFINES_SVH
`define BGD_DEFINES_SVH
// Debug clock: last count of the clk_sys divider for each source
`define BGD_ALT_LAST   3'h3
`define BGD_BUS_LAST   3'h0
// Host's slowest assumed tick and its long low time in clk_sys cycles
`define BGD_SLOW_DIV   8'h08
`define BGD_HOST_LOW   16'h0400
// Speed discovery, in ticks
`define BGD_SYNC_DET   8'h40
`define BGD_SYNC_DLY   8'h10
`define BGD_SYNC_LOW   8'h80
`define BGD_SYNC_SHIFT 7
// Bit cell, in ticks
`define BGD_BIT_ONE    5'h04
`define BGD_BIT_SAMP   5'h0a
`define BGD_BIT_ZERO   5'h0d
`define BGD_BIT_LEN    5'h10
// Command codes
`define BGD_CMD_RSTAT  8'he4
`define BGD_CMD_WCTRL  8'hc4
`define BGD_CMD_RBRK   8'he2
`define BGD_CMD_WBRK   8'hc2
// Status and control bit positions
`define BGD_B_PERMIT   7
`define BGD_B_ACTIVE   6
`define BGD_B_BRKEN    5
`define BGD_B_FTS      4
`define BGD_B_CLKSEL   3
`define BGD_B_WS       2
`define BGD_B_WSF      1
`define BGD_B_DVF      0
// Host register offsets on AHB-Lite
`define BGD_A_CTRL     8'h00
`define BGD_A_CMD      8'h04
`define BGD_A_WDATA    8'h08
`define BGD_A_RDATA    8'h0c
`define BGD_A_STATUS   8'h10
// Host control bits
`define BGD_C_SYNC     0
`define BGD_C_GO       1
`endif

// ===== bgd_pkg.sv
// Purpose: Types and command decode shared by both ends
// Assumes: bgd_defines.svh holds the numbers
// Notes:   bgd_cmd_bits is used by target and host; bgd_cmd_reads by the host only
`include "bgd_defines.svh"
package bgd_pkg;
  // Target states, one-hot
  typedef enum logic [6:0] {
    T_CMD   = 7'h01,
    T_RXD   = 7'h02,
    T_TXD   = 7'h04,
    T_SHIGH = 7'h08,
    T_SDLY  = 7'h10,
    T_SLOW  = 7'h20,
    T_SUP   = 7'h40
  } bgd_tstate_e;
  // Host states, one-hot
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_LOW  = 7'h02,
    H_UP   = 7'h04,
    H_WHI  = 7'h08,
    H_WLO  = 7'h10,
    H_MEAS = 7'h20,
    H_BIT  = 7'h40
  } bgd_hstate_e;
  // Data bits that follow a command code
  function automatic logic [4:0] bgd_cmd_bits(input logic [7:0] code);
    case (code)
      `BGD_CMD_RSTAT, `BGD_CMD_WCTRL: bgd_cmd_bits = 5'h08;
      `BGD_CMD_RBRK, `BGD_CMD_WBRK:   bgd_cmd_bits = 5'h10;
      default:                        bgd_cmd_bits = 5'h00;
    endcase
  endfunction : bgd_cmd_bits
  // Data flows target to host
  function automatic logic bgd_cmd_reads(input logic [7:0] code);
    bgd_cmd_reads = (code == `BGD_CMD_RSTAT) || (code == `BGD_CMD_RBRK);
  endfunction : bgd_cmd_reads
endpackage : bgd_pkg

// ===== bgd_link_if.sv
// Purpose: Open-drain debug pin joining host and target
// Assumes: Pull-up holds the pin high when nobody drives it
// Notes:   Output enables are active low
`timescale 1ns/1ps
interface bgd_link_if;
  logic tgtOut;     // Target drive level
  logic tgtOeN;     // Target drives pin when low
  logic hostOut;    // Host drive level
  logic hostOeN;    // Host drives pin when low
  logic pinLevel;   // Resolved wire level
  // Low wins; released pin floats high
  assign pinLevel = !((!tgtOeN && !tgtOut) || (!hostOeN && !hostOut));
  modport target (input pinLevel, output tgtOut, output tgtOeN);
  modport host   (input pinLevel, output hostOut, output hostOeN);
endinterface : bgd_link_if

// ===== bgd_target.sv
// Purpose: Target end of the single-pin background debug controller
// Assumes: Pin level synchronous to clk_sys; sys_rst is the normal reset
// Notes:   Speed discovery, register commands and address breakpoint
`timescale 1ns/1ps
`include "bgd_defines.svh"
module bgd_target import bgd_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Debug pin
  bgd_link_if.target       link,
  // Processor address and cycle strobes
  input  wire logic [15:0] cpuAddr,
  input  wire logic        cpuAccess,
  input  wire logic        cpuFetch,
  // Processor mode status
  input  wire logic        bgActive,
  input  wire logic        waitStop,
  input  wire logic        memWaitFail,
  // Breakpoint requests and permission
  output logic             breakForce,
  output logic             fetchTag,
  output logic             permitBg
);

  bgd_tstate_e state_r;          // Link state
  logic [2:0]  tickCnt_r;        // Debug clock divider
  logic        tick;             // One debug clock cycle elapsed
  logic        pinPrev_r;        // Pin level last cycle
  logic        fallEdge;         // Pin went low
  logic [7:0]  lowTicks_r;       // Ticks the pin has stayed low
  logic        syncReq;          // Long low seen
  logic [7:0]  syncCnt_r;        // Discovery phase counter
  logic        inBit_r;          // Inside a bit cell
  logic [4:0]  bitCnt_r;         // Tick within bit cell
  logic [4:0]  bitsLeft_r;       // Bits left in this phase
  logic [15:0] shift_r;          // Bit shifter
  logic [7:0]  cmd_r;            // Command being served
  logic        bitEnd;           // Bit cell bookkeeping point
  logic        lastBit;          // Phase ends with this bit
  logic        permit_r;         // Permit background state
  logic        brkEn_r;          // Breakpoint enable
  logic        fts_r;            // Force/tag select
  logic        clkSel_r;         // Link clock select
  logic        wsf_r;            // Wait/stop failure, sticky
  logic        wsfClr;           // Status read clears failure
  logic [15:0] brkAddr_r;        // Breakpoint match address
  logic [7:0]  statusByte;       // Status/control read image
  logic        brkLive;          // Breakpoint armed and matching

  // Debug clock from alternate divider or bus clock
  assign tick = clkSel_r ? (tickCnt_r == `BGD_BUS_LAST)
                         : (tickCnt_r == `BGD_ALT_LAST);
  assign fallEdge = pinPrev_r && !link.pinLevel;
  // Long low beyond any bit cell, outside our own response
  assign syncReq = (lowTicks_r == `BGD_SYNC_DET) && !state_r[5]
                   && !state_r[3] && !state_r[4] && !state_r[6];
  assign bitEnd  = inBit_r && tick && (bitCnt_r == `BGD_BIT_ZERO);
  assign lastBit = (bitsLeft_r == 5'h01);

  // Read image; fixed bits come from live status
  assign statusByte = {permit_r, bgActive, brkEn_r, fts_r,
                       clkSel_r, waitStop, wsf_r, 1'b0};
  assign wsfClr = bitEnd && lastBit && state_r[0] &&
                  (shift_r[7:0] == `BGD_CMD_RSTAT);

  // Divider restarts on each falling edge in command and data states to align bit cells
  always_ff @(posedge clk_sys) begin
    if (sys_rst || tick || (fallEdge && (state_r[0] || state_r[1] ||
        state_r[2]))) begin
      tickCnt_r <= 3'h0;
    end else begin
      tickCnt_r <= tickCnt_r + 3'h1;
    end
  end

  // Pin history and long-low measurement
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinPrev_r  <= 1'b1;
      lowTicks_r <= 8'h00;
    end else begin
      pinPrev_r <= link.pinLevel;
      if (link.pinLevel) begin
        lowTicks_r <= 8'h00;
      end else if (tick && lowTicks_r != `BGD_SYNC_DET) begin
        lowTicks_r <= lowTicks_r + 8'h01;
      end
    end
  end

  // Link state machine and bit engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r    <= T_CMD;
      syncCnt_r  <= 8'h00;
      inBit_r    <= 1'b0;
      bitCnt_r   <= 5'h00;
      bitsLeft_r <= 5'h08;
      shift_r    <= 16'h0000;
      cmd_r      <= 8'h00;
    end else if (syncReq) begin
      // Drop any command, answer discovery
      state_r    <= T_SHIGH;
      inBit_r    <= 1'b0;
      bitsLeft_r <= 5'h08;
    end else begin
      case (state_r)
        T_SHIGH: begin
          // Wait for host to let pin rise
          if (link.pinLevel) begin
            state_r   <= T_SDLY;
            syncCnt_r <= 8'h00;
          end
        end
        T_SDLY: begin
          // Quiet while host ends its speedup pulse
          if (tick) begin
            syncCnt_r <= syncCnt_r + 8'h01;
            if (syncCnt_r == `BGD_SYNC_DLY - 8'h01) begin
              state_r   <= T_SLOW;
              syncCnt_r <= 8'h00;
            end
          end
        end
        T_SLOW: begin
          // Response low time
          if (tick) begin
            syncCnt_r <= syncCnt_r + 8'h01;
            if (syncCnt_r == `BGD_SYNC_LOW - 8'h01) begin
              state_r <= T_SUP;
            end
          end
        end
        T_SUP: begin
          // One-tick high speedup, then release
          if (tick) begin
            state_r <= T_CMD;
          end
        end
        T_CMD, T_RXD, T_TXD: begin
          if (fallEdge && !inBit_r) begin
            inBit_r  <= 1'b1;
            bitCnt_r <= 5'h00;
          end else if (inBit_r && tick) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
          // Host bits sampled mid-cell
          if (inBit_r && tick && bitCnt_r == `BGD_BIT_SAMP &&
              !state_r[2]) begin
            shift_r <= {shift_r[14:0], link.pinLevel};
          end
          if (bitEnd) begin
            inBit_r    <= 1'b0;
            bitsLeft_r <= bitsLeft_r - 5'h01;
            if (state_r[2]) begin
              shift_r <= {shift_r[14:0], 1'b0};
            end
            if (lastBit && state_r[0]) begin
              cmd_r      <= shift_r[7:0];
              bitsLeft_r <= bgd_cmd_bits(shift_r[7:0]);
              case (shift_r[7:0])
                `BGD_CMD_RSTAT: begin
                  state_r <= T_TXD;
                  shift_r <= {statusByte, 8'h00};
                end
                `BGD_CMD_RBRK: begin
                  state_r <= T_TXD;
                  shift_r <= brkAddr_r;
                end
                `BGD_CMD_WCTRL, `BGD_CMD_WBRK: begin
                  state_r <= T_RXD;
                end
                default: begin
                  // Other commands are outside this slice
                  bitsLeft_r <= 5'h08;
                end
              endcase
            end else if (lastBit) begin
              state_r    <= T_CMD;
              bitsLeft_r <= 5'h08;
            end
          end
        end
        default: begin
          state_r <= T_CMD;
        end
      endcase
    end
  end

  // Control bits written by the control-write command
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      permit_r <= 1'b0;
      brkEn_r  <= 1'b0;
      fts_r    <= 1'b0;
      clkSel_r <= 1'b0;
    end else if (bitEnd && lastBit && state_r[1] &&
                 cmd_r == `BGD_CMD_WCTRL) begin
      if (!bgActive) begin
        permit_r <= shift_r[`BGD_B_PERMIT];
      end
      brkEn_r  <= shift_r[`BGD_B_BRKEN];
      fts_r    <= shift_r[`BGD_B_FTS];
      clkSel_r <= shift_r[`BGD_B_CLKSEL];
    end
  end

  // Match address, reachable only by serial write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      brkAddr_r <= 16'h0000;
    end else if (bitEnd && lastBit && state_r[1] &&
                 cmd_r == `BGD_CMD_WBRK) begin
      brkAddr_r <= shift_r;
    end
  end

  // Wait/stop failure: a new failure beats the read clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wsf_r <= 1'b0;
    end else begin
      wsf_r <= memWaitFail || (wsf_r && !wsfClr);
    end
  end

  // Breakpoint compare; disabled or unpermitted means no request
  assign brkLive = brkEn_r && permit_r && (cpuAddr == brkAddr_r);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      breakForce <= 1'b0;
      fetchTag   <= 1'b0;
    end else begin
      breakForce <= brkLive && fts_r && cpuAccess;
      fetchTag   <= brkLive && !fts_r && cpuFetch;
    end
  end

  assign permitBg = permit_r;

  // Pin drive: low in response and for zero bits, high for speedup
  assign link.tgtOut = state_r[6];
  assign link.tgtOeN = !(state_r[5] || state_r[6] ||
                         (state_r[2] && inBit_r && !shift_r[15] &&
                          bitCnt_r < `BGD_BIT_ZERO));

endmodule : bgd_target

// ===== bgd_host.sv
// Purpose: Host end of the debug link, ordered over AHB-Lite
// Assumes: One AHB-Lite master; zero wait states; pin synchronous
// Notes:   Discovery must run before commands time correctly
`timescale 1ns/1ps
`include "bgd_defines.svh"
module bgd_host import bgd_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Debug pin
  bgd_link_if.host         link
);

  bgd_hstate_e state_r;        // Link state
  logic        wrPend_r;       // Write data phase pending
  logic [7:0]  wrAddr_r;       // Captured write offset
  logic        addrOk;         // Valid address phase
  logic        wrNow;          // Write data phase this cycle
  logic [7:0]  cmd_r;          // Command code to send
  logic [15:0] wdata_r;        // Data to send
  logic [15:0] rdata_r;        // Data received
  logic        synced_r;       // Bit rate measured
  logic [7:0]  div_r;          // clk_sys cycles per tick
  logic [7:0]  hCnt_r;         // Tick divider
  logic        tick;           // Tick strobe
  logic [15:0] meas_r;         // Low-time counter
  logic [4:0]  bitCnt_r;       // Tick within bit cell
  logic [23:0] frame_r;        // Bits still to send
  logic [4:0]  txLeft_r;       // Bits to send
  logic [4:0]  rxLeft_r;       // Bits to receive
  logic        drvLow;         // Pull pin low in bit cell
  logic        cellEnd;        // End of bit cell

  assign addrOk    = hsel && htrans[1] && hready;
  assign wrNow     = wrPend_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign tick      = (hCnt_r == div_r - 8'h01);
  assign cellEnd   = tick && (bitCnt_r == `BGD_BIT_LEN - 5'h01);

  // Address phase capture and registered read data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      wrPend_r <= addrOk && hwrite;
      wrAddr_r <= haddr[7:0];
      if (addrOk && !hwrite) begin
        case (haddr[7:0])
          `BGD_A_CMD:    hrdata <= {24'h000000, cmd_r};
          `BGD_A_WDATA:  hrdata <= {16'h0000, wdata_r};
          `BGD_A_RDATA:  hrdata <= {16'h0000, rdata_r};
          `BGD_A_STATUS: hrdata <= {16'h0000, div_r, 6'h00, synced_r,
                                    !state_r[0]};
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command and data registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_r   <= 8'h00;
      wdata_r <= 16'h0000;
    end else if (wrNow && wrAddr_r == `BGD_A_CMD) begin
      cmd_r <= hwdata[7:0];
    end else if (wrNow && wrAddr_r == `BGD_A_WDATA) begin
      wdata_r <= hwdata[15:0];
    end
  end

  // Tick divider, restarted at each cell start
  always_ff @(posedge clk_sys) begin
    if (sys_rst || tick || state_r[0]) begin
      hCnt_r <= 8'h00;
    end else begin
      hCnt_r <= hCnt_r + 8'h01;
    end
  end

  // Discovery and bit-cell state machine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r  <= H_IDLE;
      synced_r <= 1'b0;
      div_r    <= `BGD_SLOW_DIV;
      meas_r   <= 16'h0000;
      bitCnt_r <= 5'h00;
      frame_r  <= 24'h000000;
      txLeft_r <= 5'h00;
      rxLeft_r <= 5'h00;
      rdata_r  <= 16'h0000;
    end else begin
      case (state_r)
        H_IDLE: begin
          meas_r   <= 16'h0000;
          bitCnt_r <= 5'h00;
          if (wrNow && wrAddr_r == `BGD_A_CTRL && hwdata[`BGD_C_SYNC]) begin
            state_r <= H_LOW;
          end else if (wrNow && wrAddr_r == `BGD_A_CTRL &&
                       hwdata[`BGD_C_GO]) begin
            state_r  <= H_BIT;
            rdata_r  <= 16'h0000;                     // Byte reads zero-fill
            txLeft_r <= bgd_cmd_reads(cmd_r) ? 5'h08
                        : 5'h08 + bgd_cmd_bits(cmd_r);
            rxLeft_r <= bgd_cmd_reads(cmd_r) ? bgd_cmd_bits(cmd_r) : 5'h00;
            frame_r  <= (bgd_cmd_bits(cmd_r) == 5'h08)
                        ? {cmd_r, wdata_r[7:0], 8'h00} : {cmd_r, wdata_r};
          end
        end
        H_LOW: begin
          // Long low, longer than the slowest response allows
          meas_r <= meas_r + 16'h0001;
          if (meas_r == `BGD_HOST_LOW - 16'h0001) begin
            state_r <= H_UP;
          end
        end
        H_UP: begin
          state_r <= H_WHI;
        end
        H_WHI: begin
          if (link.pinLevel) begin
            state_r <= H_WLO;
          end
        end
        H_WLO: begin
          meas_r <= 16'h0000;
          if (!link.pinLevel) begin
            // First low cycle is already part of the run
            state_r <= H_MEAS;
            meas_r  <= 16'h0001;
          end
        end
        H_MEAS: begin
          // Time the response low; divide by its tick count
          if (link.pinLevel) begin
            state_r  <= H_IDLE;
            synced_r <= 1'b1;
            div_r    <= (meas_r[15:`BGD_SYNC_SHIFT] == 9'h000) ? 8'h01
                        : meas_r[14:`BGD_SYNC_SHIFT];
          end else begin
            meas_r <= meas_r + 16'h0001;
          end
        end
        H_BIT: begin
          if (tick) begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
          if (tick && bitCnt_r == `BGD_BIT_SAMP && txLeft_r == 5'h00) begin
            rdata_r <= {rdata_r[14:0], link.pinLevel};
          end
          if (cellEnd) begin
            bitCnt_r <= 5'h00;
            if (txLeft_r != 5'h00) begin
              txLeft_r <= txLeft_r - 5'h01;
              frame_r  <= {frame_r[22:0], 1'b0};
              if (txLeft_r == 5'h01 && rxLeft_r == 5'h00) begin
                state_r <= H_IDLE;
              end
            end else begin
              rxLeft_r <= rxLeft_r - 5'h01;
              if (rxLeft_r == 5'h01) begin
                state_r <= H_IDLE;
              end
            end
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // Cell low time: short for one or a read, long for zero
  assign drvLow = state_r[6] && (bitCnt_r < ((txLeft_r != 5'h00 &&
                  !frame_r[23]) ? `BGD_BIT_ZERO : `BGD_BIT_ONE));
  assign link.hostOut = state_r[2];
  assign link.hostOeN = !(state_r[1] || state_r[2] || drvLow);

endmodule : bgd_host

// ===== bgd_link_properties.sv
// Purpose: Wire checks on the debug pin between host and target
// Assumes: Link clock on alternate source, four clk_sys to a tick
// Notes:   Helper counters measure drive runs on the pin
`timescale 1ns/1ps
module bgd_link_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pin drivers and level
  input wire logic tgtOut,
  input wire logic tgtOeN,
  input wire logic hostOut,
  input wire logic hostOeN,
  input wire logic pinLevel
);
  logic        tLow, tHigh, hLow, hHigh; // Decoded drives
  logic [10:0] tCnt_r, hCnt_r;           // Low run lengths
  logic [7:0]  pCnt_r;                   // Pin high run, saturating
  logic        armed_r;                  // Host long low seen
  assign tLow  = !tgtOeN && !tgtOut;
  assign tHigh = !tgtOeN && tgtOut;
  assign hLow  = !hostOeN && !hostOut;
  assign hHigh = !hostOeN && hostOut;
  // Run counters
  always_ff @(posedge clk_sys) begin
    tCnt_r <= (sys_rst || !tLow) ? 11'h0 : tCnt_r + 11'h1;
    hCnt_r <= (sys_rst || !hLow) ? 11'h0 : hCnt_r + 11'h1;
    pCnt_r <= (sys_rst || !pinLevel) ? 8'h0 : pCnt_r + {7'h0, ~&pCnt_r};
  end
  // Discovery request pending until target answers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) armed_r <= 1'b0;
    else if (hCnt_r > 300) armed_r <= 1'b1;
    else if (tLow) armed_r <= 1'b0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_host_low_len: assert property ($fell(hLow) && hCnt_r > 100 |->
    hCnt_r == 1024) else $error("host long low wrong length");
  a_host_up_pulse: assert property ($fell(hLow) && hCnt_r > 100 |->
    hHigh ##1 hostOeN[*8]) else $error("host speedup pulse wrong");
  // Sixteen ticks; the first one may be partial
  a_sync_idle: assert property ($rose(tLow) && armed_r |->
    pCnt_r >= 62 && pCnt_r <= 65) else $error("sync idle gap wrong");
  a_sync_low_len: assert property ($fell(tLow) && tCnt_r > 100 |->
    tCnt_r == 512) else $error("sync response low wrong length");
  a_sync_up_pulse: assert property ($fell(tLow) && tCnt_r > 100 |->
    tHigh[*4] ##1 tgtOeN) else $error("target speedup pulse wrong");
  a_bit_low_len: assert property ($fell(tLow) |->
    tCnt_r <= 52 || tCnt_r == 512) else $error("target low run too long");
  a_abort_low: assert property (hCnt_r > 300 |-> tgtOeN)
    else $error("target drives during long low");
  a_no_fight: assert property (!(tLow && hHigh) && !(hLow && tHigh))
    else $error("opposite drives on pin");
  c_sync_resp: cover property ($fell(tLow) && tCnt_r == 512);
  c_host_low: cover property ($fell(hLow) && hCnt_r == 1024);
  c_bit_cell: cover property ($fell(tLow) && tCnt_r < 60);
endmodule : bgd_link_properties

// ===== tb_background_debug_sync_breakpoint.sv
// Purpose: Self-checking bench for host and target across the debug pin
// Assumes: Discovery runs first; link clock stays on alternate source
// Notes:   Host registers reached by single AHB-Lite word transfers
`timescale 1ns/1ps
module tb_background_debug_sync_breakpoint;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;   // Clock, reset
  logic        hsel = 1'b0, hwrite = 1'b0;       // Bus controls
  logic [1:0]  htrans = 2'h0;                    // Transfer kind
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;    // Address, write data
  logic        hreadyout, hresp;                 // Slave answer
  logic [31:0] hrdata;                           // Read data
  logic [15:0] cpuAddr = 16'h0;                  // Processor address
  logic        cpuAccess = 1'b0, cpuFetch = 1'b0;
  logic        bgActive = 1'b0, waitStop = 1'b0, memWaitFail = 1'b0;
  logic        breakForce, fetchTag, permitBg;   // Target requests
  int          num_errors = 0, cmp_count = 0;    // Tallies
  bgd_link_if i_bgd_link_if ();
  bgd_target i_bgd_target (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(i_bgd_link_if.target), .cpuAddr(cpuAddr), .cpuAccess(cpuAccess),
    .cpuFetch(cpuFetch), .bgActive(bgActive), .waitStop(waitStop),
    .memWaitFail(memWaitFail), .breakForce(breakForce),
    .fetchTag(fetchTag), .permitBg(permitBg));
  bgd_host i_bgd_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(i_bgd_link_if.host));
  bgd_link_properties i_bgd_link_properties (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .tgtOut(i_bgd_link_if.tgtOut),
    .tgtOeN(i_bgd_link_if.tgtOeN), .hostOut(i_bgd_link_if.hostOut),
    .hostOeN(i_bgd_link_if.hostOeN), .pinLevel(i_bgd_link_if.pinLevel));
  always #2.5 clk_sys = !clk_sys;
  // One word transfer; address phase held until ready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Poll status until the link is idle
  task automatic wait_idle(output logic [31:0] r);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h10, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 5000);
    chk("idle", {15'h0, r[0]}, 16'h0);
  endtask : wait_idle
  // Send one debug command and fetch its read data
  task automatic cmd(input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] q);
    logic [31:0] r;
    bus(1'b1, 8'h04, {24'h0, c}, r);
    bus(1'b1, 8'h08, {16'h0, d}, r);
    bus(1'b1, 8'h00, 32'h2, r);
    wait_idle(r);
    bus(1'b0, 8'h0c, 32'h0, r);
    q = r[15:0];
  endtask : cmd
  task automatic t_sync();
    logic [31:0] r;
    bus(1'b1, 8'h00, 32'h1, r);
    wait_idle(r);
    chk("synced", {15'h0, r[1]}, 16'h1);
    chk("rate", {8'h0, r[15:8]}, 16'h4);
    bus(1'b0, 8'h14, 32'h0, r);
    chk("unmapped", r[15:0], 16'h0);
    chk("okay", {15'h0, hresp}, 16'h0);
    $display("test sync done");
  endtask : t_sync
  task automatic t_status();
    logic [15:0] q;
    cmd(8'he4, 16'h0, q);
    chk("reset status", q, 16'h0);
    bgActive <= 1'b1;
    cmd(8'hc4, 16'hf7, q);
    cmd(8'he4, 16'h0, q);
    chk("active status", q, 16'h70);
    bgActive <= 1'b0;
    cmd(8'hc4, 16'hf7, q);
    cmd(8'he4, 16'h0, q);
    chk("run status", q, 16'hb0);
    chk("permit", {15'h0, permitBg}, 16'h1);
    waitStop <= 1'b1;
    memWaitFail <= 1'b1;
    @(posedge clk_sys);
    memWaitFail <= 1'b0;
    cmd(8'he4, 16'h0, q);
    chk("fail status", q, 16'hb6);
    waitStop <= 1'b0;
    cmd(8'he4, 16'h0, q);
    chk("clear status", q, 16'hb0);
    $display("test status done");
  endtask : t_status
  // One processor cycle, then the two requests
  task automatic probe(input logic [15:0] a, input logic f,
                       input logic [1:0] e);
    @(posedge clk_sys);
    cpuAddr <= a;
    cpuAccess <= 1'b1;
    cpuFetch <= f;
    @(posedge clk_sys);
    cpuAccess <= 1'b0;
    cpuFetch <= 1'b0;
    #1;
    chk("break", {14'h0, breakForce, fetchTag}, {14'h0, e});
  endtask : probe
  task automatic t_brk();
    logic [15:0] q;
    cmd(8'hc2, 16'h1234, q);
    cmd(8'he2, 16'h0, q);
    chk("match", q, 16'h1234);
    probe(16'h1234, 1'b0, 2'h2);
    probe(16'h1235, 1'b0, 2'h0);
    cmd(8'hc4, 16'ha0, q);
    probe(16'h1234, 1'b1, 2'h1);
    probe(16'h1234, 1'b0, 2'h0);
    cmd(8'hc4, 16'h90, q);
    probe(16'h1234, 1'b0, 2'h0);
    $display("test breakpoint done");
  endtask : t_brk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Main sequence after reset
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_sync();
    t_status();
    t_brk();
    finish_test();
  end
  // Watchdog against a hung handshake; about three and a half times the expected run
  initial begin
    #250000;
    num_errors++;
    finish_test();
  end
endmodule : tb_background_debug_sync_breakpoint
